//--- rtl/cie_pkg.sv
// Shared constants and types for the instruction execution subset.
// Assumes a single 125 MHz clock; nothing here holds state.
`default_nettype none
package cie_pkg;

  localparam int unsigned INSTR_W     = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned FILE_DEPTH  = 128;
  localparam int unsigned PC_W        = 15;
  localparam int unsigned LATCH_W     = 7;
  localparam int unsigned BRANCH_W    = 11;
  localparam int unsigned REG_ADDR_W  = 3;
  localparam int unsigned REG_DATA_W  = 16;

  // Field positions inside an instruction word and the latch
  localparam int unsigned DEST_BIT      = 7;
  localparam int unsigned LATCH_PAGE_HI = 6;
  localparam int unsigned LATCH_PAGE_LO = 3;

  // Opcode match values and masks
  localparam logic [13:0] CLEAR_MASK  = 14'h3ff8;
  localparam logic [13:0] CLEAR_MATCH = 14'h0100;
  localparam logic [13:0] BYTE_MASK   = 14'h3f00;
  localparam logic [13:0] DEC_MATCH   = 14'h0300;
  localparam logic [13:0] DECSZ_MATCH = 14'h0b00;
  localparam logic [13:0] INCSZ_MATCH = 14'h0f00;
  localparam logic [13:0] OR_MATCH    = 14'h3800;
  localparam logic [13:0] JUMP_MASK   = 14'h3800;
  localparam logic [13:0] JUMP_MATCH  = 14'h2800;

  // Register port indices
  localparam logic [2:0] REG_LATCH  = 3'h0;
  localparam logic [2:0] REG_WORK   = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_PC     = 3'h3;

  // Values after reset
  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic [7:0]  WORK_RESET  = 8'h00;
  localparam logic        ZERO_RESET  = 1'b0;
  localparam logic [6:0]  LATCH_RESET = 7'h00;

  typedef enum logic [2:0] {
    ST_EXEC   = 3'b001,
    ST_SKIP   = 3'b010,
    ST_REFILL = 3'b100
  } cie_state_type;

  typedef enum logic [2:0] {
    OTHER_OP,
    CLEAR_WORKING_REG_OP,
    DECREMENT_FILE_OP,
    DECREMENT_SKIP_ZERO_OP,
    INCREMENT_SKIP_ZERO_OP,
    UNCONDITIONAL_BRANCH_OP,
    OR_LITERAL_OP
  } cie_op_type;

  typedef enum logic [1:0] {
    ALU_ZERO,
    ALU_DEC,
    ALU_INC,
    ALU_OR
  } cie_alu_op_type;

  function automatic cie_op_type cie_decode(input logic [13:0] ins);
    cie_op_type op;
    op = OTHER_OP;
    if ((ins & CLEAR_MASK) == CLEAR_MATCH) begin
      op = CLEAR_WORKING_REG_OP;
    end else if ((ins & BYTE_MASK) == DEC_MATCH) begin
      op = DECREMENT_FILE_OP;
    end else if ((ins & BYTE_MASK) == DECSZ_MATCH) begin
      op = DECREMENT_SKIP_ZERO_OP;
    end else if ((ins & BYTE_MASK) == INCSZ_MATCH) begin
      op = INCREMENT_SKIP_ZERO_OP;
    end else if ((ins & JUMP_MASK) == JUMP_MATCH) begin
      op = UNCONDITIONAL_BRANCH_OP;
    end else if ((ins & BYTE_MASK) == OR_MATCH) begin
      op = OR_LITERAL_OP;
    end
    return op;
  endfunction

endpackage
`default_nettype wire

//--- rtl/cie_exec_if.sv
// Internal carrier between the core, its file register bank and its ALU.
// Purely combinational wiring on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface cie_exec_if;
  import cie_pkg::*;
  logic [6:0]     fb_addr;
  logic [7:0]     fb_wdata;
  logic           fb_we;
  logic [7:0]     fb_rdata;
  cie_alu_op_type alu_op;
  logic [7:0]     alu_a;
  logic [7:0]     alu_b;
  logic [7:0]     alu_res;
  logic           alu_zero;

  modport core (output fb_addr, output fb_wdata, output fb_we, input fb_rdata,
                output alu_op, output alu_a, output alu_b, input alu_res, input alu_zero);
  modport bank (input fb_addr, input fb_wdata, input fb_we, output fb_rdata);
  modport alu  (input alu_op, input alu_a, input alu_b, output alu_res, output alu_zero);
endinterface
`default_nettype wire

//--- rtl/cie_alu.sv
// Byte ALU for the execution subset.
// Combinational; the core registers whatever it keeps.
`timescale 1ns/1ps
`default_nettype none
module cie_alu (
  cie_exec_if.alu bus
);
  import cie_pkg::*;

  always_comb begin
    case (bus.alu_op)
      ALU_ZERO: bus.alu_res = 8'h00;
      ALU_DEC:  bus.alu_res = bus.alu_a - 8'h01;
      ALU_INC:  bus.alu_res = bus.alu_a + 8'h01;
      ALU_OR:   bus.alu_res = bus.alu_a | bus.alu_b;
      default:  bus.alu_res = 8'h00;
    endcase
    bus.alu_zero = (bus.alu_res == 8'h00);
  end
endmodule
`default_nettype wire

//--- rtl/cie_file_bank.sv
// File register bank, 128 bytes of flip-flops.
// Read is combinational; write lands on the enabled clock edge.
`timescale 1ns/1ps
`default_nettype none
module cie_file_bank (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  cie_exec_if.bank  bus
);
  import cie_pkg::*;

  typedef struct packed {
    logic [FILE_DEPTH-1:0][7:0] mem;
  } cie_bank_state_type;

  cie_bank_state_type r;
  cie_bank_state_type next_r;

  always_comb begin
    next_r = r;
    if (bus.fb_we) begin
      next_r.mem[bus.fb_addr] = bus.fb_wdata;
    end
  end

  assign bus.fb_rdata = r.mem[bus.fb_addr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

//--- rtl/cie_core.sv
// Execution core for a subset of an 8-bit instruction set.
// Assumes the fetch logic on the same clock presents one instruction word
// per cycle at the address shown on pc, with instr_valid high.
`timescale 1ns/1ps
`default_nettype none
module cie_core (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic                         instr_valid,
  input  wire logic [cie_pkg::INSTR_W-1:0]  instr,
  input  wire logic [cie_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [cie_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output var  logic [cie_pkg::REG_DATA_W-1:0] reg_rdata,
  output var  logic [cie_pkg::PC_W-1:0]     pc,
  output var  logic [cie_pkg::DATA_W-1:0]   work_reg,
  output var  logic                         zero_flag,
  output var  logic                         discard_cycle
);
  import cie_pkg::*;

  typedef struct packed {
    cie_state_type state;
    logic [14:0]   pc;
    logic [7:0]    w;
    logic          z;
    logic [6:0]    latch;
    logic          busy;
    logic [15:0]   rd_data;
  } cie_core_state_type;

  localparam cie_core_state_type CORE_RESET = '{
    state:   ST_EXEC,
    pc:      PC_RESET,
    w:       WORK_RESET,
    z:       ZERO_RESET,
    latch:   LATCH_RESET,
    busy:    1'b0,
    rd_data: 16'h0000
  };

  cie_core_state_type r;
  cie_core_state_type next_r;
  cie_exec_if         bus ();
  cie_op_type         op;
  logic               dest_file;

  cie_alu u_alu (
    .bus (bus.alu)
  );

  cie_file_bank u_bank (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .bus    (bus.bank)
  );

  always_comb begin
    next_r       = r;
    op           = cie_decode(instr);
    dest_file    = instr[DEST_BIT];
    bus.fb_addr  = instr[FILE_ADDR_W-1:0];
    bus.fb_wdata = bus.alu_res;
    bus.fb_we    = 1'b0;
    bus.alu_op   = ALU_DEC;
    bus.alu_a    = bus.fb_rdata;
    bus.alu_b    = instr[DATA_W-1:0];
    case (r.state)
      ST_EXEC: begin
        if (instr_valid) begin
          next_r.pc = r.pc + 15'h0001;
          case (op)
            CLEAR_WORKING_REG_OP: begin
              bus.alu_op = ALU_ZERO;
              next_r.w   = bus.alu_res;
              next_r.z   = 1'b1;
            end
            DECREMENT_FILE_OP: begin
              bus.alu_op = ALU_DEC;
              if (dest_file) begin
                bus.fb_we = 1'b1;
              end else begin
                next_r.w = bus.alu_res;
              end
              next_r.z = bus.alu_zero;
            end
            DECREMENT_SKIP_ZERO_OP, INCREMENT_SKIP_ZERO_OP: begin
              // Flags deliberately left alone here
              bus.alu_op = (op == INCREMENT_SKIP_ZERO_OP) ? ALU_INC : ALU_DEC;
              if (dest_file) begin
                bus.fb_we = 1'b1;
              end else begin
                next_r.w = bus.alu_res;
              end
              if (bus.alu_zero) begin
                next_r.state = ST_SKIP;
              end
            end
            UNCONDITIONAL_BRANCH_OP: begin
              next_r.pc = {r.latch[LATCH_PAGE_HI:LATCH_PAGE_LO], instr[BRANCH_W-1:0]};
              next_r.state = ST_REFILL;
            end
            OR_LITERAL_OP: begin
              bus.alu_op = ALU_OR;
              bus.alu_a  = r.w;
              next_r.w   = bus.alu_res;
              next_r.z   = bus.alu_zero;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SKIP: begin
        // Word fetched here is dropped and runs as a no_operation
        if (instr_valid) begin
          next_r.pc    = r.pc + 15'h0001;
          next_r.state = ST_EXEC;
        end
      end
      ST_REFILL: begin
        // Fetch path reloads at the new pc; nothing executes
        next_r.state = ST_EXEC;
      end
      default: begin
        next_r.state = ST_EXEC;
      end
    endcase
    next_r.busy = (next_r.state != ST_EXEC);
    if (reg_wr && reg_addr == REG_LATCH) begin
      next_r.latch = reg_wdata[LATCH_W-1:0];
    end
    next_r.rd_data = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_LATCH:  next_r.rd_data = {9'h000, r.latch};
        REG_WORK:   next_r.rd_data = {8'h00, r.w};
        REG_STATUS: next_r.rd_data = {15'h0000, r.z};
        REG_PC:     next_r.rd_data = {1'b0, r.pc};
        default:    next_r.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= CORE_RESET;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign reg_rdata     = r.rd_data;
  assign pc            = r.pc;
  assign work_reg      = r.w;
  assign zero_flag     = r.z;
  assign discard_cycle = r.busy;

  // Checks
  logic       take;
  cie_op_type op_now;
  assign op_now = cie_decode(instr);
  assign take   = clk_en && instr_valid && (r.state == ST_EXEC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_clear_work;
    take && op_now == CLEAR_WORKING_REG_OP |=> r.w == 8'h00 && r.z;
  endproperty
  a_clear_work: assert property (p_clear_work) else $error("clear op result wrong");

  property p_dec_work;
    take && op_now == DECREMENT_FILE_OP && !instr[DEST_BIT]
      |=> r.w == $past(bus.fb_rdata) - 8'h01;
  endproperty
  a_dec_work: assert property (p_dec_work) else $error("decrement to working wrong");

  property p_dec_file;
    take && op_now == DECREMENT_FILE_OP && instr[DEST_BIT]
      |-> bus.fb_we && bus.fb_wdata == bus.fb_rdata - 8'h01 ##1 $stable(r.w);
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

  property p_decsz_skip;
    take && op_now == DECREMENT_SKIP_ZERO_OP && bus.fb_rdata == 8'h01
      |=> r.state == ST_SKIP && discard_cycle;
  endproperty
  a_decsz_skip: assert property (p_decsz_skip) else $error("decrement skip missing");

  property p_decsz_flags;
    take && op_now == DECREMENT_SKIP_ZERO_OP |=> r.z == $past(r.z);
  endproperty
  a_decsz_flags: assert property (p_decsz_flags) else $error("decrement skip touched flag");

  property p_incsz_skip;
    take && op_now == INCREMENT_SKIP_ZERO_OP && !instr[DEST_BIT]
      |=> r.w == $past(bus.fb_rdata) + 8'h01 && (r.state == ST_SKIP) == (r.w == 8'h00);
  endproperty
  a_incsz_skip: assert property (p_incsz_skip) else $error("increment skip wrong");

  property p_incsz_flags;
    take && op_now == INCREMENT_SKIP_ZERO_OP |=> $stable(r.z);
  endproperty
  a_incsz_flags: assert property (p_incsz_flags) else $error("increment skip touched flag");

  property p_jump_low;
    take && op_now == UNCONDITIONAL_BRANCH_OP
      |=> r.pc[BRANCH_W-1:0] == $past(instr[BRANCH_W-1:0]) && $stable(r.z);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("branch low bits wrong");

  property p_jump_high;
    take && op_now == UNCONDITIONAL_BRANCH_OP
      |=> r.pc[PC_W-1:BRANCH_W] == $past(r.latch[LATCH_PAGE_HI:LATCH_PAGE_LO]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("branch page bits wrong");

  property p_jump_refill;
    take && op_now == UNCONDITIONAL_BRANCH_OP
      |=> r.state == ST_REFILL ##1 (!$past(clk_en) || (r.state == ST_EXEC && $stable(r.pc)));
  endproperty
  a_jump_refill: assert property (p_jump_refill) else $error("branch refill wrong");

  property p_or_lit;
    take && op_now == OR_LITERAL_OP
      |=> r.w == ($past(r.w) | $past(instr[DATA_W-1:0])) && r.z == (r.w == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

  property p_zero_single;
    take && op_now == DECREMENT_FILE_OP
      |=> r.z == ($past(bus.fb_rdata) == 8'h01) && r.state == ST_EXEC
          && r.pc == $past(r.pc) + 15'h0001;
  endproperty
  a_zero_single: assert property (p_zero_single) else $error("zero flag or timing wrong");

  property p_clear_no_file;
    take && op_now == CLEAR_WORKING_REG_OP |-> !bus.fb_we;
  endproperty
  a_clear_no_file: assert property (p_clear_no_file) else $error("clear op wrote a file register");

  property p_clear_single;
    take && op_now == CLEAR_WORKING_REG_OP |=> r.state == ST_EXEC && r.pc == $past(r.pc) + 15'h0001;
  endproperty
  a_clear_single: assert property (p_clear_single) else $error("clear op timing wrong");

  property p_decsz_file;
    take && op_now == DECREMENT_SKIP_ZERO_OP && instr[DEST_BIT]
      |-> bus.fb_we && bus.fb_wdata == bus.fb_rdata - 8'h01 ##1 $stable(r.w);
  endproperty
  a_decsz_file: assert property (p_decsz_file) else $error("decrement skip to file wrong");

  property p_decsz_work;
    take && op_now == DECREMENT_SKIP_ZERO_OP && !instr[DEST_BIT]
      |=> r.w == $past(bus.fb_rdata) - 8'h01;
  endproperty
  a_decsz_work: assert property (p_decsz_work) else $error("decrement skip to working wrong");

  property p_decsz_stay;
    take && op_now == DECREMENT_SKIP_ZERO_OP && bus.fb_rdata != 8'h01
      |=> r.state == ST_EXEC && !discard_cycle;
  endproperty
  a_decsz_stay: assert property (p_decsz_stay) else $error("decrement skip on nonzero result");

  property p_incsz_file;
    take && op_now == INCREMENT_SKIP_ZERO_OP && instr[DEST_BIT]
      |-> bus.fb_we && bus.fb_wdata == bus.fb_rdata + 8'h01 ##1 $stable(r.w);
  endproperty
  a_incsz_file: assert property (p_incsz_file) else $error("increment skip to file wrong");

  property p_incsz_stay;
    take && op_now == INCREMENT_SKIP_ZERO_OP && bus.fb_rdata != 8'hff
      |=> r.state == ST_EXEC && !discard_cycle;
  endproperty
  a_incsz_stay: assert property (p_incsz_stay) else $error("increment skip on nonzero result");

  property p_incsz_wrap;
    take && op_now == INCREMENT_SKIP_ZERO_OP && bus.fb_rdata == 8'hff
      |=> r.state == ST_SKIP && discard_cycle;
  endproperty
  a_incsz_wrap: assert property (p_incsz_wrap) else $error("increment skip missing on wrap");

  property p_skip_drop;
    r.state == ST_SKIP && clk_en && instr_valid
      |=> r.state == ST_EXEC && r.pc == $past(r.pc) + 15'h0001 && $stable(r.w) && $stable(r.z);
  endproperty
  a_skip_drop: assert property (p_skip_drop) else $error("skipped word was not dropped");

  property p_skip_nowrite;
    r.state == ST_SKIP |-> !bus.fb_we;
  endproperty
  a_skip_nowrite: assert property (p_skip_nowrite) else $error("skipped word wrote a file register");

  property p_skip_wait;
    r.state == ST_SKIP && clk_en && !instr_valid |=> r.state == ST_SKIP && $stable(r.pc);
  endproperty
  a_skip_wait: assert property (p_skip_wait) else $error("skip ended without a word");

  property p_refill_hold;
    r.state == ST_REFILL && clk_en
      |=> r.state == ST_EXEC && $stable(r.pc) && $stable(r.w) && $stable(r.z);
  endproperty
  a_refill_hold: assert property (p_refill_hold) else $error("refill cycle changed state");

  property p_refill_nowrite;
    r.state == ST_REFILL |-> !bus.fb_we;
  endproperty
  a_refill_nowrite: assert property (p_refill_nowrite) else $error("refill wrote a file register");

  property p_jump_nowrite;
    take && op_now == UNCONDITIONAL_BRANCH_OP |-> !bus.fb_we ##1 $stable(r.w);
  endproperty
  a_jump_nowrite: assert property (p_jump_nowrite) else $error("branch changed data");

  property p_jump_busy;
    take && op_now == UNCONDITIONAL_BRANCH_OP |=> discard_cycle;
  endproperty
  a_jump_busy: assert property (p_jump_busy) else $error("branch second cycle not flagged");

  property p_or_nowrite;
    take && op_now == OR_LITERAL_OP |-> !bus.fb_we ##1 r.state == ST_EXEC;
  endproperty
  a_or_nowrite: assert property (p_or_nowrite) else $error("or literal wrote a file register");

  property p_other_single;
    take && op_now == OTHER_OP
      |=> r.pc == $past(r.pc) + 15'h0001 && $stable(r.w) && $stable(r.z);
  endproperty
  a_other_single: assert property (p_other_single) else $error("unlisted word not single cycle");

  c_jump:  cover property (take && op_now == UNCONDITIONAL_BRANCH_OP ##1 r.state == ST_REFILL);
  c_decsz: cover property (take && op_now == DECREMENT_SKIP_ZERO_OP ##1 r.state == ST_SKIP);
  c_incsz: cover property (take && op_now == INCREMENT_SKIP_ZERO_OP ##1 r.state == ST_SKIP);
  c_or:    cover property (take && op_now == OR_LITERAL_OP ##1 r.z);
  c_skip_wait: cover property (r.state == ST_SKIP && clk_en && !instr_valid);
endmodule
`default_nettype wire

//--- verification/cie_bench.sv
// Self-checking bench for the execution core subset.
// Drives the core ports directly; a cycle model in the bench predicts every output.
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset_bench;
  import cie_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic        instr_valid;
  logic [13:0] instr;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [14:0] pc;
  logic [7:0]  work_reg;
  logic        zero_flag;
  logic        discard_cycle;
  int          failures;
  int          num_checks;
  logic [31:0] seed;
  logic [31:0] x;
  logic [31:0] y;
  logic        e;
  logic        chk_on;
  // Model state; file bank is invisible at the ports, so the model keeps its own copy
  logic [7:0]  m_file [128];
  logic [14:0] m_pc;
  logic [7:0]  m_w;
  logic        m_z;
  logic [6:0]  m_lat;
  logic [15:0] m_rd;
  logic [1:0]  m_st;
  logic [7:0]  r;
  logic [6:0]  f;
  logic [13:0] corner [15] = '{14'h0100, 14'h0f80, 14'h0b01, 14'h0382, 14'h0f82,
                               14'h38ff, 14'h3800, 14'h0100, 14'h3800, 14'h0b80,
                               14'h2fff, 14'h2fff, 14'h2800, 14'h2800, 14'h0100};

  cie_core dut_u (
    .clk           (clk),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .instr_valid   (instr_valid),
    .instr         (instr),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .pc            (pc),
    .work_reg      (work_reg),
    .zero_flag     (zero_flag),
    .discard_cycle (discard_cycle)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_read(input logic [2:0] a);
    case (a)
      REG_LATCH:  return {9'h000, m_lat};
      REG_WORK:   return {8'h00, m_w};
      REG_STATUS: return {15'h0000, m_z};
      REG_PC:     return {1'b0, m_pc};
      default:    return 16'h0000;
    endcase
  endfunction

  // Small address set so skip counts reach zero often
  function automatic logic [13:0] rand_instr(input logic [31:0] v);
    logic [13:0] byte_op;
    byte_op = {6'h00, v[15], 4'h0, v[18:16]};
    case (v[2:0])
      3'd0:       return CLEAR_MATCH | {11'h000, v[10:8]};
      3'd1:       return DEC_MATCH | byte_op;
      3'd2:       return DECSZ_MATCH | byte_op;
      3'd3, 3'd6: return INCSZ_MATCH | byte_op;
      3'd4:       return JUMP_MATCH | {3'h0, v[26:16]};
      3'd5:       return OR_MATCH | {6'h00, v[31] ? v[27:20] : 8'h00};
      default:    return v[29:16];
    endcase
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_pc = PC_RESET;
      m_w = WORK_RESET;
      m_z = ZERO_RESET;
      m_lat = LATCH_RESET;
      m_rd = 16'h0000;
      m_st = 2'd0;
      for (int i = 0; i < 128; i++) m_file[i] = 8'h00;
    end else if (clk_en) begin
      m_rd = reg_rd ? exp_read(reg_addr) : 16'h0000;
      f = instr[6:0];
      if (m_st == 2'd2) begin
        m_st = 2'd0;
      end else if (instr_valid && m_st == 2'd1) begin
        m_st = 2'd0;
        m_pc = m_pc + 15'h0001;
      end else if (instr_valid) begin
        m_pc = m_pc + 15'h0001;
        if ((instr & CLEAR_MASK) == CLEAR_MATCH) begin
          m_w = 8'h00;
          m_z = 1'b1;
        end else if ((instr & JUMP_MASK) == JUMP_MATCH) begin
          m_pc = {m_lat[6:3], instr[10:0]};
          m_st = 2'd2;
        end else if ((instr & BYTE_MASK) == OR_MATCH) begin
          m_w = m_w | instr[7:0];
          m_z = (m_w == 8'h00);
        end else if ((instr & BYTE_MASK) == DEC_MATCH || (instr & BYTE_MASK) == DECSZ_MATCH ||
                     (instr & BYTE_MASK) == INCSZ_MATCH) begin
          r = ((instr & BYTE_MASK) == INCSZ_MATCH) ? m_file[f] + 8'h01 : m_file[f] - 8'h01;
          if (instr[DEST_BIT]) m_file[f] = r;
          else m_w = r;
          if ((instr & BYTE_MASK) == DEC_MATCH) m_z = (r == 8'h00);
          else if (r == 8'h00) m_st = 2'd1;
        end
      end
      // Latch change lands after the branch has used the old page
      if (reg_wr && reg_addr == REG_LATCH) m_lat = reg_wdata[6:0];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(negedge clk) begin
    if (chk_on) begin
      chk({1'b0, pc}, {1'b0, m_pc}, "pc");
      chk({8'h00, work_reg}, {8'h00, m_w}, "working register");
      chk({15'h0000, zero_flag}, {15'h0000, m_z}, "zero flag");
      chk({15'h0000, discard_cycle}, {15'h0000, m_st != 2'd0}, "discard");
      chk(reg_rdata, m_rd, "read data");
    end
  end

  task automatic drive(input logic [13:0] i, input logic v, input logic en, input logic rd,
                       input logic wr, input logic [2:0] a, input logic [15:0] wd);
    @(posedge clk);
    instr       <= i;
    instr_valid <= v;
    clk_en      <= en;
    reg_rd      <= rd;
    reg_wr      <= wr;
    reg_addr    <= a;
    reg_wdata   <= wd;
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Run limit; the whole sequence needs about 3070 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("wrong value at %0t: run limit reached", $time);
    print_verdict();
  end

  initial begin
    seed = 32'h0000ad4b;
    rst_n = 1'b0;
    clk_en = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk_on = 1'b0;
    failures = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk_on <= 1'b1;
    for (int a = 0; a < 8; a++) drive(14'h0000, 1'b0, 1'b1, 1'b1, 1'b0, a[2:0], 16'h0000);
    drive(14'h0000, 1'b0, 1'b1, 1'b0, 1'b1, REG_LATCH, 16'h0058);
    $display("test reset values done");
    foreach (corner[k]) drive(corner[k], 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0000);
    $display("test corner cases done");
    for (int n = 0; n < 3000; n++) begin
      x = next_rand();
      y = next_rand();
      e = (y[3:0] != 4'h0);
      drive(rand_instr(x), y[8:6] != 3'd0, e, e && y[5:4] == 2'd0, e && y[5:4] == 2'd1,
            y[11:9], y[31:16]);
    end
    $display("test random stream done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) drive(14'h0000, 1'b0, 1'b1, 1'b1, 1'b0, a[2:0], 16'h0000);
    foreach (corner[k]) drive(corner[k], 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0000);
    drive(14'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0000);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
